// [rtl/bss_pkg.sv]
package bss_pkg;

    // ------------------------------------------------------------
    // boot source encodings (fuse field values)
    // ------------------------------------------------------------
    typedef enum logic [3:0]
    {
        BSS_SRC_PINS    = 4'h0,
        BSS_SRC_ISP0    = 4'h1,
        BSS_SRC_QUAD    = 4'h2,
        BSS_SRC_EMC8    = 4'h3,
        BSS_SRC_EMC16   = 4'h4,
        BSS_SRC_EMC32   = 4'h5,
        BSS_SRC_USB_PORT_ZERO    = 4'h6,
        BSS_SRC_USB_PORT_ONE    = 4'h7,
        BSS_SRC_SSP     = 4'h8,
        BSS_SRC_ISP3    = 4'h9
    } bss_src_t;

    // ------------------------------------------------------------
    // pin patterns {sel3,sel2,sel1,sel0} for a zero fuse field
    // ------------------------------------------------------------
    localparam logic [3:0] BSS_PIN_ISP0  = 4'h0;
    localparam logic [3:0] BSS_PIN_QUAD  = 4'h1;
    localparam logic [3:0] BSS_PIN_EMC8  = 4'h2;
    localparam logic [3:0] BSS_PIN_EMC16 = 4'h3;
    localparam logic [3:0] BSS_PIN_EMC32 = 4'h4;
    localparam logic [3:0] BSS_PIN_USB_PORT_ZERO  = 4'h5;
    localparam logic [3:0] BSS_PIN_USB_PORT_ONE  = 4'h6;
    localparam logic [3:0] BSS_PIN_SSP   = 4'h7;
    localparam logic [3:0] BSS_PIN_ISP3  = 4'h8;

    // ------------------------------------------------------------
    // rom and boot vector
    // ------------------------------------------------------------
    localparam int          BSS_ROM_KB     = 64;
    localparam int          BSS_ROM_AW     = 16;
    localparam logic [15:0] BSS_ROM_BYTES_M1 = 16'hffff;
    localparam logic [15:0] BSS_ROM_START  = 16'h0000;

    // ------------------------------------------------------------
    // shared flash pin function codes
    // ------------------------------------------------------------
    localparam logic [1:0]  BSS_PF_GPIO    = 2'h0;
    localparam logic [1:0]  BSS_PF_QUAD    = 2'h1;
    localparam logic [1:0]  BSS_PF_SSP     = 2'h2;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [3:0]  BSS_RST_SRC    = 4'h1;
    localparam logic [1:0]  BSS_RST_PF     = 2'h0;

endpackage

// [rtl/bss_decode.sv]
`timescale 1ns/1ps
`default_nettype none
// combinational boot source decoder
module bss_decode
(
    input  wire logic [3:0] fuse_i,
    input  wire logic       fuse_prog_i,
    input  wire logic [3:0] pins_i,
    output logic      [3:0] src_o,
    output logic            rsvd_o
);
    // ------------------------------------------------------------
    // pin pattern to source code
    // ------------------------------------------------------------
    function automatic logic [4:0] pin_map(input logic [3:0] p);
        unique case (p)
            bss_pkg::BSS_PIN_ISP0:  pin_map = {1'b0, bss_pkg::BSS_SRC_ISP0};
            bss_pkg::BSS_PIN_QUAD:  pin_map = {1'b0, bss_pkg::BSS_SRC_QUAD};
            bss_pkg::BSS_PIN_EMC8:  pin_map = {1'b0, bss_pkg::BSS_SRC_EMC8};
            bss_pkg::BSS_PIN_EMC16: pin_map = {1'b0, bss_pkg::BSS_SRC_EMC16};
            bss_pkg::BSS_PIN_EMC32: pin_map = {1'b0, bss_pkg::BSS_SRC_EMC32};
            bss_pkg::BSS_PIN_USB_PORT_ZERO:  pin_map = {1'b0, bss_pkg::BSS_SRC_USB_PORT_ZERO};
            bss_pkg::BSS_PIN_USB_PORT_ONE:  pin_map = {1'b0, bss_pkg::BSS_SRC_USB_PORT_ONE};
            bss_pkg::BSS_PIN_SSP:   pin_map = {1'b0, bss_pkg::BSS_SRC_SSP};
            bss_pkg::BSS_PIN_ISP3:  pin_map = {1'b0, bss_pkg::BSS_SRC_ISP3};
            default:                pin_map = {1'b1, bss_pkg::BSS_RST_SRC};
        endcase
    endfunction

    // ------------------------------------------------------------
    // fuse first, pins when fuse is zero or unprogrammed
    // ------------------------------------------------------------
    always_comb
    begin
        logic [4:0] pm;
        pm = pin_map(pins_i);
        if (!fuse_prog_i || fuse_i == bss_pkg::BSS_SRC_PINS)
        begin
            src_o  = pm[3:0];
            rsvd_o = pm[4];
        end
        else if (fuse_i > bss_pkg::BSS_SRC_ISP3)
        begin
            src_o  = bss_pkg::BSS_RST_SRC;
            rsvd_o = 1'b1;
        end
        else
        begin
            src_o  = fuse_i;
            rsvd_o = 1'b0;
        end
    end
endmodule // bss_decode
`default_nettype wire

// [rtl/bss_boot_select.sv]
`timescale 1ns/1ps
`default_nettype none
module bss_boot_select
(
    input  wire logic        CLK_I,
    input  wire logic        RESET_I,
    input  wire logic        CE_I,
    input  wire logic        BOOT_GATE_PIN_I,
    input  wire logic [3:0]  BOOT_SELECT_PIN_I,
    input  wire logic [3:0]  BOOT_SOURCE_FUSE_FIELD_I,
    input  wire logic        FUSE_PROGRAMMED_I,
    output logic             SELECT_DONE_O,
    output logic      [3:0]  BOOT_SOURCE_O,
    output logic             BOOT_RESERVED_O,
    output logic             BOOT_FIXED_O,
    output logic             FETCH_FROM_ROM_O,
    output logic      [15:0] ROM_START_ADDR_O,
    output logic      [15:0] ROM_LAST_ADDR_O,
    output logic      [1:0]  FLASH_PIN_FUNC_O
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {BSS_SYNC, BSS_SAMPLE, BSS_HOLD} bss_state_t;

    bss_state_t  state_reg, state_next;
    logic [4:0]  sync1_reg, sync2_reg;
    logic [3:0]  src_reg, src_next;
    logic        rsvd_reg, rsvd_next;
    logic        fixed_reg, fixed_next;
    logic        done_reg, done_next;
    logic        rom_reg, rom_next;
    logic [1:0]  pf_reg, pf_next;
    logic [3:0]  dec_src;
    logic        dec_rsvd;
    logic        sync_cnt_reg, sync_cnt_next;

    // ------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
        begin
            sync1_reg <= 5'h00;
            sync2_reg <= 5'h00;
        end
        else if (CE_I)
        begin
            sync1_reg <= {BOOT_GATE_PIN_I, BOOT_SELECT_PIN_I};
            sync2_reg <= sync1_reg;
        end
    end

    // ------------------------------------------------------------
    // decoder
    // ------------------------------------------------------------
    bss_decode u_dec
    (
        .fuse_i      (BOOT_SOURCE_FUSE_FIELD_I),
        .fuse_prog_i (FUSE_PROGRAMMED_I),
        .pins_i      (sync2_reg[3:0]),
        .src_o       (dec_src),
        .rsvd_o      (dec_rsvd)
    );

    // ------------------------------------------------------------
    // pin function for the chosen flash path
    // ------------------------------------------------------------
    function automatic logic [1:0] pin_func(input logic [3:0] s);
        if (s == bss_pkg::BSS_SRC_QUAD)
            pin_func = bss_pkg::BSS_PF_QUAD;
        else if (s == bss_pkg::BSS_SRC_SSP)
            pin_func = bss_pkg::BSS_PF_SSP;
        else
            pin_func = bss_pkg::BSS_PF_GPIO;
    endfunction

    // ------------------------------------------------------------
    // sample once after reset release, then hold
    // ------------------------------------------------------------
    always_comb
    begin
        state_next    = state_reg;
        src_next      = src_reg;
        rsvd_next     = rsvd_reg;
        fixed_next    = fixed_reg;
        done_next     = done_reg;
        rom_next      = rom_reg;
        pf_next       = pf_reg;
        sync_cnt_next = sync_cnt_reg;
        unique case (state_reg)
            BSS_SYNC:
            begin
                // wait for the synchroniser to fill
                sync_cnt_next = 1'b1;
                if (sync_cnt_reg)
                    state_next = BSS_SAMPLE;
            end
            BSS_SAMPLE:
            begin
                // pins assumed stable through reset
                if (sync2_reg[4])
                begin
                    // gate high: fixed default source, no selection
                    src_next   = bss_pkg::BSS_RST_SRC;
                    rsvd_next  = 1'b0;
                    fixed_next = 1'b1;
                end
                else
                begin
                    src_next   = dec_src;
                    rsvd_next  = dec_rsvd;
                    fixed_next = 1'b0;
                end
                pf_next    = sync2_reg[4] ? bss_pkg::BSS_PF_GPIO
                                          : pin_func(dec_src);
                done_next  = 1'b1;
                state_next = BSS_HOLD;
            end
            BSS_HOLD:
            begin
                rom_next = 1'b1;  // rom keeps executing the loader
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
        begin
            state_reg    <= BSS_SYNC;
            src_reg      <= bss_pkg::BSS_RST_SRC;
            rsvd_reg     <= 1'b0;
            fixed_reg    <= 1'b0;
            done_reg     <= 1'b0;
            rom_reg      <= 1'b1;
            pf_reg       <= bss_pkg::BSS_RST_PF;
            sync_cnt_reg <= 1'b0;
        end
        else if (CE_I)
        begin
            state_reg    <= state_next;
            src_reg      <= src_next;
            rsvd_reg     <= rsvd_next;
            fixed_reg    <= fixed_next;
            done_reg     <= done_next;
            rom_reg      <= rom_next;
            pf_reg       <= pf_next;
            sync_cnt_reg <= sync_cnt_next;
        end
    end

    // ------------------------------------------------------------
    // rom window: constant flops, 64 kB
    // ------------------------------------------------------------
    logic [15:0] start_reg, last_reg;
    always_ff @(posedge CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
        begin
            start_reg <= bss_pkg::BSS_ROM_START;
            last_reg  <= bss_pkg::BSS_ROM_BYTES_M1;
        end
        else if (CE_I)
        begin
            start_reg <= bss_pkg::BSS_ROM_START;
            last_reg  <= bss_pkg::BSS_ROM_BYTES_M1;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign SELECT_DONE_O    = done_reg;
    assign BOOT_SOURCE_O    = src_reg;
    assign BOOT_RESERVED_O  = rsvd_reg;
    assign BOOT_FIXED_O     = fixed_reg;
    assign FETCH_FROM_ROM_O = rom_reg;
    assign ROM_START_ADDR_O = start_reg;
    assign ROM_LAST_ADDR_O  = last_reg;
    assign FLASH_PIN_FUNC_O = pf_reg;

endmodule // bss_boot_select
`default_nettype wire

// [tb/bss_strap_model.sv]
`timescale 1ns/1ps
`default_nettype none
// board strap pins and one-time fuses seen by the boot selector
module bss_strap_model
(
    output logic       gate_o,
    output logic [3:0] pins_o,
    output logic [3:0] fuse_o,
    output logic       prog_o
);
    // levels change only when the bench loads a new board setup
    task automatic load(input logic g, input logic [3:0] p,
                        input logic [3:0] f, input logic pr);
        gate_o = g;
        pins_o = p;
        fuse_o = f;
        prog_o = pr;
    endtask
endmodule // bss_strap_model
`default_nettype wire

// [tb/bss_boot_select_chk.sv]
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// boot selector port checker
// ------------------------------------------------------------
module bss_boot_select_chk
(
    input wire logic        CLK_I,
    input wire logic        RESET_I,
    input wire logic        CE_I,
    input wire logic        BOOT_GATE_PIN_I,
    input wire logic [3:0]  BOOT_SELECT_PIN_I,
    input wire logic [3:0]  BOOT_SOURCE_FUSE_FIELD_I,
    input wire logic        FUSE_PROGRAMMED_I,
    input wire logic        SELECT_DONE_O,
    input wire logic [3:0]  BOOT_SOURCE_O,
    input wire logic        BOOT_RESERVED_O,
    input wire logic        BOOT_FIXED_O,
    input wire logic        FETCH_FROM_ROM_O,
    input wire logic [15:0] ROM_START_ADDR_O,
    input wire logic [15:0] ROM_LAST_ADDR_O,
    input wire logic [1:0]  FLASH_PIN_FUNC_O
);
    // pins decide when the fuse field is zero or unprogrammed
    wire use_pins = !FUSE_PROGRAMMED_I || BOOT_SOURCE_FUSE_FIELD_I == 4'h0;
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RESET_I);
    // three enabled edges after release, decision not yet shown
    sequence s_go;
        $fell(RESET_I) ##0 (CE_I && !SELECT_DONE_O) [*3];
    endsequence
    // a fresh decision with the gate pin low
    // straps may move once the decision is out, so use the values of the
    // edge that latched it
    sequence s_new;
        $rose(SELECT_DONE_O) && !$past(BOOT_GATE_PIN_I);
    endsequence
    property p_fetch; FETCH_FROM_ROM_O; endproperty
    a_fetch: assert property (p_fetch) else $error("rom fetch low");
    property p_rom;
        ROM_START_ADDR_O == 16'h0000 && ROM_LAST_ADDR_O == 16'hffff;
    endproperty
    a_rom: assert property (p_rom) else $error("rom range wrong");
    property p_lat; s_go |=> SELECT_DONE_O; endproperty
    a_lat: assert property (p_lat) else $error("decision late");
    property p_hold;
        SELECT_DONE_O |=> SELECT_DONE_O && $stable(BOOT_SOURCE_O);
    endproperty
    a_hold: assert property (p_hold) else $error("decision moved");
    property p_gate;
        $rose(SELECT_DONE_O) |-> BOOT_FIXED_O == $past(BOOT_GATE_PIN_I)
            && (!$past(BOOT_GATE_PIN_I) || BOOT_SOURCE_O == 4'h1);
    endproperty
    a_gate: assert property (p_gate) else $error("gate ignored");
    property p_fuse;
        s_new ##0 (!$past(use_pins) && $past(BOOT_SOURCE_FUSE_FIELD_I) < 4'ha)
            |-> BOOT_SOURCE_O == $past(BOOT_SOURCE_FUSE_FIELD_I);
    endproperty
    a_fuse: assert property (p_fuse) else $error("fuse source wrong");
    property p_pins;
        s_new ##0 ($past(use_pins) && $past(BOOT_SELECT_PIN_I) < 4'h9)
            |-> BOOT_SOURCE_O == $past(BOOT_SELECT_PIN_I) + 4'h1;
    endproperty
    a_pins: assert property (p_pins) else $error("pin source wrong");
    property p_rsvd;
        s_new |-> BOOT_RESERVED_O == ($past(use_pins)
            ? $past(BOOT_SELECT_PIN_I) > 4'h8
            : $past(BOOT_SOURCE_FUSE_FIELD_I) > 4'h9);
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved flag wrong");
    property p_safe; BOOT_RESERVED_O |-> BOOT_SOURCE_O == 4'h1; endproperty
    a_safe: assert property (p_safe) else $error("unsafe fallback");
    property p_pf;
        SELECT_DONE_O |-> FLASH_PIN_FUNC_O == (BOOT_SOURCE_O == 4'h2 ? 2'h1
            : BOOT_SOURCE_O == 4'h8 ? 2'h2 : 2'h0);
    endproperty
    a_pf: assert property (p_pf) else $error("pin function wrong");
endmodule // bss_boot_select_chk
bind bss_boot_select bss_boot_select_chk i_chk (.*);
`default_nettype wire

// [tb/bss_boot_select_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) \
    begin \
        compares++; \
        if ((a) !== (e)) \
        begin \
            num_errors++; \
            $display("[FAIL] %s exp %h got %h", n, e, a); \
        end \
    end
module bss_boot_select_tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        ce  = 1'b1;
    logic        gate, prog, done, rsvd, fixed, fetch;
    logic [3:0]  pins, fuse, src;
    logic [15:0] a0, a1;
    logic [1:0]  pf;
    logic [7:0]  exp_q[$];
    logic [7:0]  want;
    int          num_errors = 0;
    int          compares = 0;

    bss_strap_model i_straps (.gate_o(gate), .pins_o(pins), .fuse_o(fuse),
        .prog_o(prog));
    bss_boot_select i_dut (.CLK_I(clk), .RESET_I(rst), .CE_I(ce),
        .BOOT_GATE_PIN_I(gate), .BOOT_SELECT_PIN_I(pins),
        .BOOT_SOURCE_FUSE_FIELD_I(fuse), .FUSE_PROGRAMMED_I(prog),
        .SELECT_DONE_O(done), .BOOT_SOURCE_O(src), .BOOT_RESERVED_O(rsvd),
        .BOOT_FIXED_O(fixed), .FETCH_FROM_ROM_O(fetch),
        .ROM_START_ADDR_O(a0), .ROM_LAST_ADDR_O(a1), .FLASH_PIN_FUNC_O(pf));

    // clock and watchdog
    initial forever #5 clk = ~clk;
    initial
    begin
        #100000;
        num_errors++;
        report_and_stop();
    end

    // expected {source, reserved, fixed, pin function}
    function automatic logic [7:0] expect_of(logic g, logic [3:0] p,
                                             logic [3:0] f, logic pr);
        logic [3:0] s;
        logic       r;
        if (g)
            return {4'h1, 2'b01, 2'h0};
        if (pr && f != 4'h0)
            {r, s} = (f < 4'ha) ? {1'b0, f} : {1'b1, 4'h1};
        else
            {r, s} = (p < 4'h9) ? {1'b0, p + 4'h1} : {1'b1, 4'h1};
        return {s, r, 1'b0, s == 4'h2 ? 2'h1 : s == 4'h8 ? 2'h2 : 2'h0};
    endfunction

    // one reset with a board setup, then straps disturbed after decision
    task automatic run(input logic g, input logic [3:0] p,
                       input logic [3:0] f, input logic pr);
        logic [7:0] e;
        @(negedge clk);
        rst = 1'b1;
        ce = 1'b1;
        i_straps.load(g, p, f, pr);
        e = expect_of(g, p, f, pr);
        exp_q.push_back(e);
        repeat (8) @(negedge clk);
        rst = 1'b0;
        for (int n = 0; n < 40 && done !== 1'b1; n++)
        begin
            @(negedge clk);
            ce = ($urandom % 4) != 0;
        end
        ce = 1'b1;
        i_straps.load(1'($urandom), 4'($urandom), 4'($urandom), 1'b1);
        repeat (4) @(negedge clk);
        `CHK("held", e, {src, rsvd, fixed, pf})
        $display("test g=%0d p=%h f=%h pr=%0d ended", g, p, f, pr);
    endtask

    task automatic report_and_stop();
        if (exp_q.size() != 0)
            num_errors++;
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // scoreboard takes the oldest note at each new decision
    initial
    forever
    begin
        @(posedge done);
        #1;
        want = exp_q.pop_front();
        `CHK("decision", want, {src, rsvd, fixed, pf})
        `CHK("fetch", 1'b1, fetch)
        `CHK("rom", 32'h0000ffff, {a0, a1})
    end

    // every fuse code, every pin pattern, then random setups
    initial
    begin
        i_straps.load(1'b0, 4'h0, 4'h0, 1'b0);
        void'($urandom(32'h00b23292));
        for (int i = 0; i < 16; i++)
            run(1'b0, 4'($urandom), 4'(i), 1'b1);
        for (int i = 0; i < 16; i++)
            run(1'b0, 4'(i), 4'(i * 7), 1'b0);
        for (int i = 0; i < 12; i++)
            run(1'($urandom), 4'($urandom), 4'($urandom), 1'($urandom));
        report_and_stop();
    end
endmodule // bss_boot_select_tb
`default_nettype wire
